// ### dmal_consts.vh
// shared constants of the dma list and guard block: register indices, fields, counts
// assumes inclusion by bare name from every design file that needs them
`ifndef DMAL_CONSTS_VH
`define DMAL_CONSTS_VH
// ----------------------------------------------------------------
// register indices inside one channel window (byte address = index * 4)
// ----------------------------------------------------------------
`define DMAL_IDX_SRC 4'h0
`define DMAL_IDX_DST 4'h1
`define DMAL_IDX_LEN 4'h2
`define DMAL_IDX_CTRL 4'h3
`define DMAL_IDX_RDCFG 4'h4
`define DMAL_IDX_WRCFG 4'h5
`define DMAL_IDX_MODE 4'h6
`define DMAL_IDX_EN 4'h7
`define DMAL_IDX_START 4'h8
`define DMAL_IDX_MSTAT 4'h9
`define DMAL_IDX_RSTAT 4'ha
`define DMAL_IDX_MASK 4'hb
`define DMAL_IDX_ACT 4'hc
// ----------------------------------------------------------------
// field positions
// ----------------------------------------------------------------
`define DMAL_CTL_INT 0
`define DMAL_CTL_LAST 1
`define DMAL_TOK_HI 21
`define DMAL_TOK_LO 16
`define DMAL_INCR_BIT 31
`define DMAL_SWAP_HI 17
`define DMAL_SWAP_LO 16
`define DMAL_ST_END 0
`define DMAL_ST_TORD 1
`define DMAL_ST_TOWR 2
`define DMAL_ST_STALL 3
// ----------------------------------------------------------------
// reset values and bus codes
// ----------------------------------------------------------------
`define DMAL_RST_WORD 32'h0000_0000
`define DMAL_RST_NIB 4'h0
`define DMAL_HTRANS_IDLE 2'b00
`define DMAL_HTRANS_NONSEQ 2'b10
`define DMAL_HSIZE_WORD 3'b010
`define DMAL_WORD_STEP 32'h0000_0004
`define DMAL_LEN_STEP 13'h0004
// ----------------------------------------------------------------
// timing counts, in clock cycles as printed
// ----------------------------------------------------------------
`define DMAL_BUS_TO_CYC 11'd1024
`define DMAL_WD_CYC 12'd2048
`endif

// ### dmal_monitor.sv
// concurrent checks on the ports of the dma list and guard top
// assumes one clock and a synchronous active-high reset
`default_nettype none
module dmal_monitor (
  input wire logic clock_i, // clock
  input wire logic rst_i, // reset
  input wire logic s_hsel_i, // select
  input wire logic [31:0] s_haddr_i, // reg address
  input wire logic [1:0] s_htrans_i, // reg transfer
  input wire logic s_hwrite_i, // reg write
  input wire logic s_hready_i, // bus ready
  input wire logic [31:0] s_hrdata_o, // reg read data
  input wire logic s_hreadyout_o, // reg ready
  input wire logic s_hresp_o, // reg response
  input wire logic [31:0] m_haddr_o, // master address
  input wire logic [1:0] m_htrans_o, // master transfer
  input wire logic m_hwrite_o, // master write
  input wire logic [2:0] m_hsize_o, // master size
  input wire logic [31:0] m_hwdata_o, // master write data
  input wire logic m_hready_i // master ready
);
  timeunit 1ns;
  timeprecision 1ps;
  // ----------------------------------------
  // helper logic
  // ----------------------------------------
  logic [10:0] wait_cnt_reg; // address phase wait length
  logic rd_take; // register read accepted
  assign rd_take = s_hsel_i && s_htrans_i[1] && s_hready_i && !s_hwrite_i;
  // count consecutive unanswered address phase cycles
  always_ff @(posedge clock_i) begin
    if (rst_i || !(m_htrans_o == 2'b10 && !m_hready_i)) begin
      wait_cnt_reg <= 11'h000;
    end else if (wait_cnt_reg != 11'h7ff) begin
      wait_cnt_reg <= wait_cnt_reg + 11'h001;
    end
  end
  // ----------------------------------------
  // assertions
  // ----------------------------------------
  default clocking cb @(posedge clock_i); endclocking
  default disable iff (rst_i);
  sequence s_wr_take;
    m_htrans_o == 2'b10 && m_hwrite_o && m_hready_i;
  endsequence
  sequence s_wr_wait;
    s_wr_take ##1 !m_hready_i;
  endsequence
  a_slave_okay: assert property (s_hreadyout_o && !s_hresp_o)
    else $error("register slave not ready or not okay");
  a_word_aligned: assert property (
    m_htrans_o == 2'b10 |-> m_hsize_o == 3'b010 && m_haddr_o[1:0] == 2'b00)
    else $error("master transfer not an aligned word");
  a_single_only: assert property (m_htrans_o == 2'b00 || m_htrans_o == 2'b10)
    else $error("master transfer type not idle or nonseq");
  a_addr_held: assert property (
    m_htrans_o == 2'b10 && !m_hready_i |=> $stable(m_haddr_o) && $stable(m_hwrite_o))
    else $error("master address changed while waiting");
  a_idle_after_write: assert property (s_wr_take |=> m_htrans_o == 2'b00)
    else $error("no idle after a write burst");
  a_wdata_held: assert property (s_wr_wait |=> $stable(m_hwdata_o))
    else $error("write data changed in data phase");
  a_bus_timeout: assert property (wait_cnt_reg <= 11'd1025)
    else $error("address phase not aborted after timeout");
  a_rdata_stands: assert property (!rd_take |=> $stable(s_hrdata_o))
    else $error("read data changed without a read");
  a_unmapped_zero: assert property (rd_take && s_haddr_i[31:8] != 24'h0 |=> s_hrdata_o == 32'h0)
    else $error("unmapped read not zero");
endmodule
bind dmal_top dmal_monitor u_dmal_monitor (.clock_i(clock_i), .rst_i(rst_i),
  .s_hsel_i(s_hsel_i), .s_haddr_i(s_haddr_i), .s_htrans_i(s_htrans_i),
  .s_hwrite_i(s_hwrite_i), .s_hready_i(s_hready_i), .s_hrdata_o(s_hrdata_o),
  .s_hreadyout_o(s_hreadyout_o), .s_hresp_o(s_hresp_o), .m_haddr_o(m_haddr_o),
  .m_htrans_o(m_htrans_o), .m_hwrite_o(m_hwrite_o), .m_hsize_o(m_hsize_o),
  .m_hwdata_o(m_hwdata_o), .m_hready_i(m_hready_i));
`default_nettype wire

// ### dmal_ram.sv
// ahb-lite word memory on the master port of the dma top
// assumes single word transfers; stall_i withholds ready, slow_i adds waits
`default_nettype none
module dmal_ram (
  input wire logic clock_i, // clock
  input wire logic rst_i, // reset
  input wire logic [31:0] haddr_i, // address
  input wire logic [1:0] htrans_i, // transfer type
  input wire logic hwrite_i, // write
  input wire logic [31:0] hwdata_i, // write data
  input wire logic stall_i, // never answer
  input wire logic slow_i, // wait states
  output logic [31:0] hrdata_o, // read data
  output logic hready_o // ready
);
  timeunit 1ns;
  timeprecision 1ps;
  logic [31:0] mem [0:255]; // word storage
  logic dph_reg; // data phase open
  logic wr_reg; // data phase is a write
  logic [7:0] idx_reg; // data phase word
  logic [31:0] junk_reg; // moving value off the bus
  // real data only in a read data phase, else a pattern
  assign hrdata_o = (dph_reg && !wr_reg) ? mem[idx_reg] : junk_reg;
  // address capture, write commit and ready pacing
  always @(posedge clock_i) begin
    if (rst_i) begin
      dph_reg <= 1'b0;
      hready_o <= 1'b1;
      junk_reg <= 32'h0;
    end else begin
      if (hready_o) begin
        dph_reg <= htrans_i[1];
        wr_reg <= hwrite_i;
        idx_reg <= haddr_i[9:2];
      end
      if (hready_o && dph_reg && wr_reg) begin
        mem[idx_reg] <= hwdata_i;
      end
      hready_o <= !stall_i && !(slow_i && hready_o);
      junk_reg <= ~junk_reg ^ 32'h5a5a0f0f;
    end
  end
endmodule
`default_nettype wire

// ### dmal_swap.v
// byte order rearrangement of one 32-bit word for the write path
// assumes a 2-bit select that is stable while the word is used
`default_nettype none
module dmal_swap (
  input wire [31:0] data_i, // word as read
  input wire [1:0] sel_i,   // byte order select
  output reg [31:0] data_o  // word as written
);
  // ----------------------------------------------------------------
  // order select
  // ----------------------------------------------------------------
  always @* begin
    case (sel_i)
      2'h0: data_o = data_i; // no swap
      2'h1: data_o = {data_i[23:16], data_i[31:24], data_i[7:0], data_i[15:8]}; // in halves
      2'h2: data_o = {data_i[15:0], data_i[31:16]}; // halves exchanged
      default: data_o = {data_i[7:0], data_i[15:8], data_i[23:16], data_i[31:24]}; // full
    endcase
  end
endmodule
`default_nettype wire

// ### dmal_top.v
// four-channel dma engine: command lists, tokens, byte swap, bus timeout, stall watchdog
// assumes one clock, a synchronous reset, a zero-wait register slave and one master port
`default_nettype none
`include "dmal_consts.vh"
module dmal_top (
  input wire clock_i,          // system clock
  input wire rst_i,            // synchronous reset, high
  input wire s_hsel_i,         // slave select
  input wire [31:0] s_haddr_i, // slave address
  input wire [1:0] s_htrans_i, // slave transfer type
  input wire s_hwrite_i,       // slave write
  input wire [2:0] s_hsize_i,  // slave size, word only
  input wire [31:0] s_hwdata_i,// slave write data
  input wire s_hready_i,       // bus ready
  output reg [31:0] s_hrdata_o,// slave read data
  output reg s_hreadyout_o,    // slave ready
  output reg s_hresp_o,        // slave response
  output reg [31:0] m_haddr_o, // master address
  output reg [1:0] m_htrans_o, // master transfer type
  output reg m_hwrite_o,       // master write
  output reg [2:0] m_hsize_o,  // master size
  output reg [31:0] m_hwdata_o,// master write data
  input wire [31:0] m_hrdata_i,// master read data
  input wire m_hready_i,       // master ready
  output reg irq_o             // interrupt, high while unmasked status set
);
  // ----------------------------------------------------------------
  // states and storage
  // ----------------------------------------------------------------
  localparam S_IDLE = 4'h0;
  localparam S_FETCH_A = 4'h1;
  localparam S_FETCH_D = 4'h2;
  localparam S_CHK = 4'h3;
  localparam S_RD_A = 4'h4;
  localparam S_RD_D = 4'h5;
  localparam S_WR_A = 4'h6;
  localparam S_WR_D = 4'h7;
  localparam S_DONE = 4'h8;
  reg [31:0] src_reg [0:3];     // current source address
  reg [31:0] dst_reg [0:3];     // current destination address
  reg [12:0] len_reg [0:3];     // remaining bytes
  reg [31:0] current_command_control_reg [0:3]; // interrupt, last, link
  reg [31:0] read_side_config_reg [0:3];  // read tokens, increment
  reg [31:0] write_side_config_reg [0:3]; // write tokens, increment
  reg [31:0] channel_mode_config_reg [0:3]; // byte order select
  reg [3:0] irq_raw_status_reg [0:3];     // sticky events
  reg [3:0] mask_reg [0:3];     // interrupt mask
  reg [3:0] en_reg;             // channel enable
  reg [3:0] run_reg;            // started, not ended
  reg [3:0] st_reg;             // engine state
  reg [1:0] cur_reg;            // channel holding the bus
  reg [1:0] rr_reg;             // last granted channel
  reg [5:0] tok_reg;            // bursts left in this grant
  reg [31:0] fbase_reg;         // descriptor byte address
  reg [1:0] fidx_reg;           // descriptor word index
  reg [31:0] data_reg;          // word in flight
  reg [10:0] to_cnt_reg;        // bus wait counter
  reg [1:0] wd_ch_reg;          // channel under watch
  reg [11:0] wd_cnt_reg;        // watch counter
  reg wr_pend_reg;              // register write in data phase
  reg [1:0] wr_ch_reg;          // channel of that write
  reg [3:0] wr_idx_reg;         // index of that write
  // ----------------------------------------------------------------
  // combinational helpers
  // ----------------------------------------------------------------
  wire [31:0] swapped;          // write data after reorder
  wire [3:0] active = en_reg & run_reg; // enabled and not ended
  wire s_take = s_hsel_i & s_htrans_i[1] & s_hready_i; // slave address phase
  wire [1:0] s_ch = s_haddr_i[7:6]; // channel window
  wire [3:0] s_idx = s_haddr_i[5:2]; // register index
  wire s_map = (s_haddr_i[31:8] == 24'h000000); // mapped window
  wire rd_side = (st_reg == S_FETCH_A) | (st_reg == S_FETCH_D) |
                 (st_reg == S_RD_A) | (st_reg == S_RD_D); // read direction
  wire wr_side = (st_reg == S_WR_A) | (st_reg == S_WR_D); // write direction
  wire bus_wait = rd_side | wr_side; // engine owns a transfer
  reg [1:0] pick;               // next channel to grant
  wire [5:0] rd_tok = read_side_config_reg[pick][`DMAL_TOK_HI:`DMAL_TOK_LO];
  wire [5:0] wr_tok = write_side_config_reg[pick][`DMAL_TOK_HI:`DMAL_TOK_LO];
  reg pick_ok;                  // some channel is eligible
  reg [1:0] cand;               // candidate in the scan
  reg [5:0] pick_tok;           // quota of picked channel
  reg [31:0] rd_mux;            // register read value
  integer k;
  integer i;

  // byte order of the written word
  dmal_swap u_swap (
    .data_i(data_reg),
    .sel_i(channel_mode_config_reg[cur_reg][`DMAL_SWAP_HI:`DMAL_SWAP_LO]),
    .data_o(swapped)
  );

  // round robin scan after the last grant
  always @* begin
    pick = rr_reg;
    pick_ok = 1'b0;
    cand = rr_reg;
    for (k = 1; k <= 4; k = k + 1) begin
      cand = rr_reg + k[1:0];
      if (!pick_ok && active[cand]) begin
        pick = cand;
        pick_ok = 1'b1;
      end
    end
  end

  // smaller of the two quotas, zero counted as one
  always @* begin
    pick_tok = (rd_tok < wr_tok) ? rd_tok : wr_tok;
    if (pick_tok == 6'h00) begin
      pick_tok = 6'h01;
    end
  end

  // register read value
  always @* begin
    case (s_idx)
      `DMAL_IDX_SRC: rd_mux = src_reg[s_ch];
      `DMAL_IDX_DST: rd_mux = dst_reg[s_ch];
      `DMAL_IDX_LEN: rd_mux = {19'h00000, len_reg[s_ch]};
      `DMAL_IDX_CTRL: rd_mux = current_command_control_reg[s_ch];
      `DMAL_IDX_RDCFG: rd_mux = read_side_config_reg[s_ch];
      `DMAL_IDX_WRCFG: rd_mux = write_side_config_reg[s_ch];
      `DMAL_IDX_MODE: rd_mux = channel_mode_config_reg[s_ch];
      `DMAL_IDX_EN: rd_mux = {31'h00000000, en_reg[s_ch]};
      `DMAL_IDX_START: rd_mux = {31'h00000000, run_reg[s_ch]};
      `DMAL_IDX_MSTAT: rd_mux = {28'h0000000, irq_raw_status_reg[s_ch] & mask_reg[s_ch]};
      `DMAL_IDX_RSTAT: rd_mux = {28'h0000000, irq_raw_status_reg[s_ch]};
      `DMAL_IDX_MASK: rd_mux = {28'h0000000, mask_reg[s_ch]};
      // busy bits follow the engine, zero once halted
      `DMAL_IDX_ACT: rd_mux = {30'h00000000, wr_side & (cur_reg == s_ch),
                               rd_side & (cur_reg == s_ch)};
      default: rd_mux = `DMAL_RST_WORD; // unused index
    endcase
    if (!s_map) begin
      rd_mux = `DMAL_RST_WORD; // unmapped reads zero
    end
  end

  // ----------------------------------------------------------------
  // register slave, engine, watchdog
  // ----------------------------------------------------------------
  always @(posedge clock_i) begin
    if (rst_i) begin
      for (i = 0; i < 4; i = i + 1) begin
        src_reg[i] <= `DMAL_RST_WORD;
        dst_reg[i] <= `DMAL_RST_WORD;
        len_reg[i] <= 13'h0000;
        current_command_control_reg[i] <= `DMAL_RST_WORD;
        read_side_config_reg[i] <= `DMAL_RST_WORD;
        write_side_config_reg[i] <= `DMAL_RST_WORD;
        channel_mode_config_reg[i] <= `DMAL_RST_WORD;
        irq_raw_status_reg[i] <= `DMAL_RST_NIB;
        mask_reg[i] <= `DMAL_RST_NIB;
      end
      en_reg <= 4'h0;
      run_reg <= 4'h0;
      st_reg <= S_IDLE;
      cur_reg <= 2'h0;
      rr_reg <= 2'h3;
      tok_reg <= 6'h00;
      fbase_reg <= `DMAL_RST_WORD;
      fidx_reg <= 2'h0;
      data_reg <= `DMAL_RST_WORD;
      to_cnt_reg <= 11'h000;
      wd_ch_reg <= 2'h0;
      wd_cnt_reg <= 12'h000;
      wr_pend_reg <= 1'b0;
      wr_ch_reg <= 2'h0;
      wr_idx_reg <= 4'h0;
      s_hrdata_o <= `DMAL_RST_WORD;
      s_hreadyout_o <= 1'b1;
      s_hresp_o <= 1'b0;
      m_haddr_o <= `DMAL_RST_WORD;
      m_htrans_o <= `DMAL_HTRANS_IDLE;
      m_hwrite_o <= 1'b0;
      m_hsize_o <= `DMAL_HSIZE_WORD;
      m_hwdata_o <= `DMAL_RST_WORD;
      irq_o <= 1'b0;
    end else begin
      // slave address phase: read data and read-to-clear status
      wr_pend_reg <= s_take & s_hwrite_i & s_map;
      wr_ch_reg <= s_ch;
      wr_idx_reg <= s_idx;
      if (s_take && !s_hwrite_i) begin
        s_hrdata_o <= rd_mux;
        if (s_map && (s_idx == `DMAL_IDX_MSTAT || s_idx == `DMAL_IDX_RSTAT)) begin
          irq_raw_status_reg[s_ch] <= `DMAL_RST_NIB;
        end
      end
      // slave data phase of a write
      if (wr_pend_reg) begin
        case (wr_idx_reg)
          `DMAL_IDX_SRC: src_reg[wr_ch_reg] <= s_hwdata_i;
          `DMAL_IDX_DST: dst_reg[wr_ch_reg] <= s_hwdata_i;
          `DMAL_IDX_LEN: len_reg[wr_ch_reg] <= s_hwdata_i[12:0];
          `DMAL_IDX_CTRL: current_command_control_reg[wr_ch_reg] <= s_hwdata_i;
          `DMAL_IDX_RDCFG: read_side_config_reg[wr_ch_reg] <= s_hwdata_i;
          `DMAL_IDX_WRCFG: write_side_config_reg[wr_ch_reg] <= s_hwdata_i;
          `DMAL_IDX_MODE: channel_mode_config_reg[wr_ch_reg] <= s_hwdata_i;
          `DMAL_IDX_EN: en_reg[wr_ch_reg] <= s_hwdata_i[0];
          `DMAL_IDX_START: begin
            if (s_hwdata_i[0]) begin
              run_reg[wr_ch_reg] <= 1'b1; // start from the loaded command
            end
          end
          `DMAL_IDX_MASK: mask_reg[wr_ch_reg] <= s_hwdata_i[3:0];
          default: ; // read-only or unused
        endcase
      end
      // bus wait counter, reset on every ready
      if (bus_wait && !m_hready_i) begin
        to_cnt_reg <= to_cnt_reg + 11'd1;
      end else begin
        to_cnt_reg <= 11'h000;
      end
      // engine
      case (st_reg)
        S_IDLE: begin
          if (pick_ok) begin
            cur_reg <= pick;
            rr_reg <= pick;
            st_reg <= S_CHK;
          end
        end
        S_CHK: begin
          if (len_reg[cur_reg] == 13'h0000) begin
            st_reg <= S_DONE; // empty buffer moves nothing
          end else if (tok_reg == 6'h00 || !en_reg[cur_reg]) begin
            st_reg <= S_IDLE; // quota spent or paused: release
          end else begin
            m_haddr_o <= src_reg[cur_reg];
            m_htrans_o <= `DMAL_HTRANS_NONSEQ;
            m_hwrite_o <= 1'b0;
            st_reg <= S_RD_A;
          end
        end
        S_FETCH_A, S_RD_A, S_WR_A: begin
          if (m_hready_i) begin
            m_htrans_o <= `DMAL_HTRANS_IDLE;
            m_hwdata_o <= swapped;
            st_reg <= st_reg + 4'h1;
          end
        end
        S_FETCH_D: begin
          if (m_hready_i) begin
            // four words in order
            case (fidx_reg)
              2'h0: src_reg[cur_reg] <= m_hrdata_i;
              2'h1: dst_reg[cur_reg] <= m_hrdata_i;
              2'h2: len_reg[cur_reg] <= m_hrdata_i[12:0];
              default: current_command_control_reg[cur_reg] <= m_hrdata_i;
            endcase
            fidx_reg <= fidx_reg + 2'h1;
            if (fidx_reg == 2'h3) begin
              st_reg <= S_CHK;
            end else begin
              m_haddr_o <= fbase_reg + {28'h0000000, fidx_reg + 2'h1, 2'b00};
              m_htrans_o <= `DMAL_HTRANS_NONSEQ;
              st_reg <= S_FETCH_A;
            end
          end
        end
        S_RD_D: begin
          if (m_hready_i) begin
            data_reg <= m_hrdata_i;
            m_haddr_o <= dst_reg[cur_reg];
            m_htrans_o <= `DMAL_HTRANS_NONSEQ;
            m_hwrite_o <= 1'b1;
            st_reg <= S_WR_A;
          end
        end
        S_WR_D: begin
          if (m_hready_i) begin
            m_hwrite_o <= 1'b0;
            if (read_side_config_reg[cur_reg][`DMAL_INCR_BIT]) begin
              src_reg[cur_reg] <= src_reg[cur_reg] + `DMAL_WORD_STEP;
            end
            if (write_side_config_reg[cur_reg][`DMAL_INCR_BIT]) begin
              dst_reg[cur_reg] <= dst_reg[cur_reg] + `DMAL_WORD_STEP;
            end
            if (len_reg[cur_reg] <= `DMAL_LEN_STEP) begin
              len_reg[cur_reg] <= 13'h0000;
            end else begin
              len_reg[cur_reg] <= len_reg[cur_reg] - `DMAL_LEN_STEP;
            end
            tok_reg <= tok_reg - 6'h01; // one read and one write burst used
            st_reg <= S_CHK;
          end
        end
        S_DONE: begin
          if (current_command_control_reg[cur_reg][`DMAL_CTL_LAST]) begin
            run_reg[cur_reg] <= 1'b0; // halt, no further fetch
            st_reg <= S_IDLE;
          end else begin
            // fetch the linked descriptor; loops back forever if cyclic
            fbase_reg <= {current_command_control_reg[cur_reg][31:2], 2'b00};
            m_haddr_o <= {current_command_control_reg[cur_reg][31:2], 2'b00};
            m_htrans_o <= `DMAL_HTRANS_NONSEQ;
            m_hwrite_o <= 1'b0;
            fidx_reg <= 2'h0;
            st_reg <= S_FETCH_A;
          end
        end
        default: st_reg <= S_IDLE;
      endcase
      // quota loaded at each grant
      if (st_reg == S_IDLE && pick_ok) begin
        tok_reg <= pick_tok;
      end
      // bus timeout: the requesting channel flags its own direction
      if (bus_wait && !m_hready_i && to_cnt_reg == `DMAL_BUS_TO_CYC - 11'd1) begin
        if (rd_side) begin
          irq_raw_status_reg[cur_reg][`DMAL_ST_TORD] <= 1'b1;
        end else begin
          irq_raw_status_reg[cur_reg][`DMAL_ST_TOWR] <= 1'b1;
        end
        run_reg[cur_reg] <= 1'b0;
        m_htrans_o <= `DMAL_HTRANS_IDLE;
        m_hwrite_o <= 1'b0;
        st_reg <= S_IDLE;
      end
      // completion event, set after any read-clear
      if (st_reg == S_DONE && current_command_control_reg[cur_reg][`DMAL_CTL_INT]) begin
        irq_raw_status_reg[cur_reg][`DMAL_ST_END] <= 1'b1;
      end
      // watchdog: skip idle channels, watch active ones in turn
      if (!active[wd_ch_reg] || (st_reg != S_IDLE && cur_reg == wd_ch_reg)) begin
        wd_ch_reg <= wd_ch_reg + 2'h1;
        wd_cnt_reg <= 12'h000;
      end else if (wd_cnt_reg == `DMAL_WD_CYC - 12'd1) begin
        irq_raw_status_reg[wd_ch_reg][`DMAL_ST_STALL] <= 1'b1;
        wd_ch_reg <= wd_ch_reg + 2'h1;
        wd_cnt_reg <= 12'h000;
      end else begin
        wd_cnt_reg <= wd_cnt_reg + 12'd1;
      end
      // one interrupt line for all channels
      irq_o <= |((irq_raw_status_reg[0] & mask_reg[0]) | (irq_raw_status_reg[1] & mask_reg[1]) |
                 (irq_raw_status_reg[2] & mask_reg[2]) | (irq_raw_status_reg[3] & mask_reg[3]));
    end
  end
endmodule
`default_nettype wire

// ### dmal_top_tb.sv
// self-checking bench of the dma list and guard top
// assumes the ram model on the master port and the bound checker
`default_nettype none
`include "dmal_consts.vh"
module dmal_top_tb;
  timeunit 1ns;
  timeprecision 1ps;
  logic clock_i = 1'b0; // clock
  logic rst_i = 1'b1; // reset
  logic hsel = 1'b0; // reg select
  logic [31:0] haddr = 32'h0; // reg address
  logic [1:0] htrans = 2'b00; // reg transfer
  logic hwrite = 1'b0; // reg write
  logic [31:0] hwdata = 32'h0; // reg write data
  logic stall = 1'b0; // ram silent
  logic slow = 1'b0; // ram waits
  wire [31:0] rdata, m_haddr, m_hwdata, m_hrdata;
  wire [1:0] m_htrans;
  wire rdy, m_hwrite, m_hready, irq;
  int n_fail = 0;
  int n_checks = 0;
  int n_xfer = 0; // master transfers taken
  int b; // loop index
  int n0; // transfer count at start
  logic [31:0] v; // read result
  logic [31:0] w; // source word
  always #2 clock_i = ~clock_i;
  dmal_top u_dmal_top (.clock_i(clock_i), .rst_i(rst_i), .s_hsel_i(hsel), .s_haddr_i(haddr),
    .s_htrans_i(htrans), .s_hwrite_i(hwrite), .s_hsize_i(3'b010), .s_hwdata_i(hwdata),
    .s_hready_i(rdy), .s_hrdata_o(rdata), .s_hreadyout_o(rdy), .s_hresp_o(),
    .m_haddr_o(m_haddr), .m_htrans_o(m_htrans), .m_hwrite_o(m_hwrite), .m_hsize_o(),
    .m_hwdata_o(m_hwdata), .m_hrdata_i(m_hrdata), .m_hready_i(m_hready), .irq_o(irq));
  dmal_ram u_dmal_ram (.clock_i(clock_i), .rst_i(rst_i), .haddr_i(m_haddr),
    .htrans_i(m_htrans), .hwrite_i(m_hwrite), .hwdata_i(m_hwdata), .stall_i(stall),
    .slow_i(slow), .hrdata_o(m_hrdata), .hready_o(m_hready));
  // count master transfers taken
  always @(posedge clock_i) if (m_htrans[1] && m_hready) n_xfer <= n_xfer + 1;
  // ----------------------------------------
  // tasks
  // ----------------------------------------
  task automatic chk(input logic [31:0] seen, input logic [31:0] exp);
    n_checks++;
    if (seen !== exp) begin
      n_fail++;
      $display("BAD t=%0t seen=%h exp=%h", $time, seen, exp);
    end
  endtask
  task automatic stop_test();
    $display("checks %0d mismatches %0d", n_checks, n_fail);
    if (n_fail == 0 && n_checks > 0) begin
      $display("TEST PASSED");
    end else begin
      $display("TEST FAILED");
    end
    $finish;
  endtask
  // wait for register ready (sel 0) or interrupt (sel 1)
  task automatic wait_on(input logic sel, input int lim);
    for (int i = 0; i < lim; i++) begin
      @(posedge clock_i);
      if ((sel ? irq : rdy) === 1'b1) return;
    end
    n_fail++;
    stop_test();
  endtask
  // one ahb-lite single transfer, read data left in v
  task automatic xfer(input logic wr, input logic [31:0] a, input logic [31:0] d);
    hsel <= 1'b1;
    haddr <= a;
    hwrite <= wr;
    htrans <= 2'b10;
    wait_on(1'b0, 20);
    htrans <= 2'b00;
    hwdata <= d;
    wait_on(1'b0, 20);
    v = rdata;
  endtask
  function automatic logic [31:0] ra(input int ch, input logic [3:0] idx);
    return {24'h0, ch[1:0], idx, 2'b00};
  endfunction
  task automatic put_desc(input int a, input logic [31:0] s, d, n, lk, input logic [1:0] f);
    u_dmal_ram.mem[a / 4] = s;
    u_dmal_ram.mem[a / 4 + 1] = d;
    u_dmal_ram.mem[a / 4 + 2] = n;
    u_dmal_ram.mem[a / 4 + 3] = {lk[31:2], f};
  endtask
  task automatic load_cmd(input int ch, input logic [31:0] s, d, n, c);
    xfer(1'b1, ra(ch, `DMAL_IDX_SRC), s);
    xfer(1'b1, ra(ch, `DMAL_IDX_DST), d);
    xfer(1'b1, ra(ch, `DMAL_IDX_LEN), n);
    xfer(1'b1, ra(ch, `DMAL_IDX_CTRL), c);
    n0 = n_xfer;
    xfer(1'b1, ra(ch, `DMAL_IDX_START), 32'h1);
  endtask
  task automatic setup_ch(input int ch, input logic [31:0] mask);
    xfer(1'b1, ra(ch, `DMAL_IDX_RDCFG), 32'h80010000);
    xfer(1'b1, ra(ch, `DMAL_IDX_WRCFG), 32'h80010000);
    xfer(1'b1, ra(ch, `DMAL_IDX_MASK), mask);
    xfer(1'b1, ra(ch, `DMAL_IDX_EN), 32'h1);
  endtask
  // after a run: bus quiet, end status, interrupt cleared, idle
  task automatic done_chk(input int nexp);
    repeat (20) @(posedge clock_i);
    chk(32'(n_xfer - n0), 32'(nexp));
    xfer(1'b0, ra(0, `DMAL_IDX_MSTAT), 32'h0);
    chk(v, 32'h1);
    repeat (3) @(posedge clock_i);
    chk({31'h0, irq}, 32'h0);
    xfer(1'b0, ra(0, `DMAL_IDX_ACT), 32'h0);
    chk(v, 32'h0);
  endtask
  // ----------------------------------------
  // main sequence
  // ----------------------------------------
  initial begin
    for (b = 0; b < 256; b++) u_dmal_ram.mem[b] = 32'ha1b2c3d4 + 32'(b);
    repeat (10) @(posedge clock_i);
    rst_i <= 1'b0;
    for (b = 0; b < 14; b++) begin
      xfer(1'b0, ra(0, b[3:0]), 32'h0);
      chk(v, 32'h0);
    end
    xfer(1'b0, 32'h00000100, 32'h0);
    chk(v, 32'h0);
    setup_ch(0, 32'hf);
    // single last command under every byte order
    for (b = 0; b < 4; b++) begin
      w = u_dmal_ram.mem[128 + b];
      xfer(1'b1, ra(0, `DMAL_IDX_MODE), {14'h0, b[1:0], 16'h0});
      load_cmd(0, 32'h200 + 32'(4 * b), 32'h300 + 32'(4 * b), 32'h4, 32'h3);
      wait_on(1'b1, 400);
      chk(u_dmal_ram.mem[192 + b], b == 0 ? w : b == 1 ? {w[23:16], w[31:24], w[7:0], w[15:8]}
        : b == 2 ? {w[15:0], w[31:16]} : {w[7:0], w[15:8], w[23:16], w[31:24]});
      done_chk(2);
    end
    // list of three with a zero length middle, slow memory
    slow <= 1'b1;
    xfer(1'b1, ra(0, `DMAL_IDX_MODE), 32'h0);
    put_desc(32'h100, 32'h200, 32'h380, 32'h8, 32'h140, 2'b00);
    put_desc(32'h140, 32'h0, 32'h0, 32'h0, 32'h180, 2'b00);
    put_desc(32'h180, 32'h208, 32'h390, 32'h4, 32'h0, 2'b11);
    load_cmd(0, 32'h0, 32'h0, 32'h0, 32'h100);
    wait_on(1'b1, 2000);
    chk(u_dmal_ram.mem[224], u_dmal_ram.mem[128]);
    chk(u_dmal_ram.mem[225], u_dmal_ram.mem[129]);
    chk(u_dmal_ram.mem[228], u_dmal_ram.mem[130]);
    done_chk(18);
    slow <= 1'b0;
    // cyclic list keeps raising completions
    setup_ch(1, 32'hf);
    put_desc(32'h1c0, 32'h200, 32'h3a0, 32'h4, 32'h1d0, 2'b01);
    put_desc(32'h1d0, 32'h204, 32'h3a4, 32'h4, 32'h1c0, 2'b01);
    load_cmd(1, 32'h0, 32'h0, 32'h0, 32'h1c0);
    for (b = 0; b < 3; b++) begin
      wait_on(1'b1, 2000);
      xfer(1'b0, ra(1, `DMAL_IDX_MSTAT), 32'h0);
      chk(v, 32'h1);
    end
    chk(u_dmal_ram.mem[233], u_dmal_ram.mem[129]);
    xfer(1'b1, ra(1, `DMAL_IDX_EN), 32'h0);
    repeat (50) @(posedge clock_i);
    xfer(1'b0, ra(1, `DMAL_IDX_MSTAT), 32'h0);
    // silent memory: timeout on channel 2, masked then unmasked
    setup_ch(2, 32'h0);
    stall <= 1'b1;
    load_cmd(2, 32'h200, 32'h3b0, 32'h4, 32'h3);
    repeat (1100) @(posedge clock_i);
    chk({31'h0, irq}, 32'h0);
    xfer(1'b1, ra(2, `DMAL_IDX_MASK), 32'hf);
    repeat (3) @(posedge clock_i);
    chk({31'h0, irq}, 32'h1);
    xfer(1'b0, ra(2, `DMAL_IDX_MSTAT), 32'h0);
    chk(v, 32'h2);
    xfer(1'b0, ra(0, `DMAL_IDX_RSTAT), 32'h0);
    chk(v, 32'h0);
    repeat (3) @(posedge clock_i);
    chk({31'h0, irq}, 32'h0);
    stall <= 1'b0;
    stop_test();
  end
endmodule
`default_nettype wire
